/* rtl/wdo_watchdog_ocp_ctrl.sv */
/*
 Top of the watchdog and overcurrent shutdown control block: four 8-bit
 registers, the watchdog downcounter and the overcurrent turn-off decision.
 Assumes a synchronous 8-bit register port (write strobe, read data next
 cycle), a one-second tick and a load-state level from logic on mclk.
*/
// Functional notes
// - Control bit 0 enables the watchdog and lets the downcounter run.
// - Writing 1 to control bit 1 reloads the counter and the bit clears itself; 0 does nothing.
// - The period is the field value plus one seconds, 1 s to 256 s.
// - The control register resets to zero, bits 7 to 2 reserved.
// - The period register returns to zero on entering the configuration-load state.
// - Overcurrent on a switcher output with its bit set turns the device off.
// - Overcurrent on a linear regulator with its bit set turns the device off.
// - The switcher shutdown register returns to zero in the configuration-load state.
// - The linear shutdown register returns to zero on entering the configuration-load state.
`timescale 1ns/1ps
module wdo_watchdog_ocp_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // System events
   input wire logic secTick,
   input wire logic loadState,
   input wire logic [6:0] switcherOcp,
   input wire logic [5:0] linearOcp,
   // Results
   output logic watchdogExpire,
   output logic ocpTurnOff
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] period_r;
   logic [7:0] period_nxt;
   logic [7:0] swOcp_r;
   logic [7:0] swOcp_nxt;
   logic [7:0] linOcp_r;
   logic [7:0] linOcp_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic reloadPulse_r;
   logic reloadPulse_nxt;
   logic loadState_r;
   logic loadEntry;
   logic expireInt;
   logic turnOffInt;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction : hit

   // Entry edge of the configuration-load state
   assign loadEntry = loadState & ~loadState_r;

   ////////////////////////////////////////////////////////////////////////
   // Register writes and defaults
   always_comb begin
      ctrl_nxt = ctrl_r;
      period_nxt = period_r;
      swOcp_nxt = swOcp_r;
      linOcp_nxt = linOcp_r;
      reloadPulse_nxt = 1'b0;
      // Reload bit is never stored and always reads back 0
      ctrl_nxt[wdo_pkg::WDO_BIT_RELOAD] = 1'b0;
      if (regWrite && hit(regAddr, wdo_pkg::WDO_ADDR_CTRL)) begin
         ctrl_nxt[wdo_pkg::WDO_BIT_ENABLE] = regWdata[wdo_pkg::WDO_BIT_ENABLE];
         if (regWdata[wdo_pkg::WDO_BIT_RELOAD]) begin
            reloadPulse_nxt = 1'b1;
         end
      end
      if (regWrite && hit(regAddr, wdo_pkg::WDO_ADDR_PERIOD)) begin
         period_nxt = regWdata;
      end
      if (regWrite && hit(regAddr, wdo_pkg::WDO_ADDR_SW_OCP)) begin
         swOcp_nxt = regWdata & wdo_pkg::WDO_MASK_SW_OCP;
      end
      if (regWrite && hit(regAddr, wdo_pkg::WDO_ADDR_LIN_OCP)) begin
         linOcp_nxt = regWdata & wdo_pkg::WDO_MASK_LIN_OCP;
      end
      if (loadEntry) begin
         period_nxt = wdo_pkg::WDO_RST_PERIOD;
         linOcp_nxt = wdo_pkg::WDO_RST_LIN_OCP;
      end
      if (loadState) begin
         swOcp_nxt = wdo_pkg::WDO_RST_SW_OCP;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= wdo_pkg::WDO_RST_CTRL;
         period_r <= wdo_pkg::WDO_RST_PERIOD;
         swOcp_r <= wdo_pkg::WDO_RST_SW_OCP;
         linOcp_r <= wdo_pkg::WDO_RST_LIN_OCP;
         reloadPulse_r <= 1'b0;
         loadState_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         period_r <= period_nxt;
         swOcp_r <= swOcp_nxt;
         linOcp_r <= linOcp_nxt;
         reloadPulse_r <= reloadPulse_nxt;
         loadState_r <= loadState;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read, one cycle after the strobe
   always_comb begin
      rdata_nxt = rdata_r;
      if (regRead) begin
         if (hit(regAddr, wdo_pkg::WDO_ADDR_CTRL)) begin
            rdata_nxt = ctrl_r & wdo_pkg::WDO_MASK_CTRL;
         end else if (hit(regAddr, wdo_pkg::WDO_ADDR_PERIOD)) begin
            rdata_nxt = period_r;
         end else if (hit(regAddr, wdo_pkg::WDO_ADDR_SW_OCP)) begin
            rdata_nxt = swOcp_r;
         end else if (hit(regAddr, wdo_pkg::WDO_ADDR_LIN_OCP)) begin
            rdata_nxt = linOcp_r;
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   wdo_downcounter u_counter (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(ctrl_r[wdo_pkg::WDO_BIT_ENABLE]),
      .reload(reloadPulse_r),
      .period(period_r),
      .secTick(secTick),
      .expire(expireInt),
      .count()
   );

   wdo_ocp_shutdown u_ocp (
      .mclk(mclk),
      .rst_n(rst_n),
      .switcherMask(swOcp_r[wdo_pkg::WDO_SW_SOURCES-1:0]),
      .linearMask(linOcp_r[wdo_pkg::WDO_LIN_SOURCES-1:0]),
      .switcherOcp(switcherOcp),
      .linearOcp(linearOcp),
      .turnOff(turnOffInt)
   );

   assign regRdata = rdata_r;
   assign watchdogExpire = expireInt;
   assign ocpTurnOff = turnOffInt;
endmodule : wdo_watchdog_ocp_ctrl

/* rtl/wdo_pkg.sv */
/*
 Package for the watchdog and overcurrent shutdown control block: register
 offsets, field positions, reset values and state types.
 Assumes an 8-bit register port with 8-bit addresses.
*/
package wdo_pkg;
   localparam logic [7:0] WDO_ADDR_CTRL = 8'h1B;
   localparam logic [7:0] WDO_ADDR_PERIOD = 8'h1C;
   localparam logic [7:0] WDO_ADDR_SW_OCP = 8'h1D;
   localparam logic [7:0] WDO_ADDR_LIN_OCP = 8'h1E;
   localparam logic [7:0] WDO_RST_CTRL = 8'h00;
   localparam logic [7:0] WDO_RST_PERIOD = 8'h00;
   localparam logic [7:0] WDO_RST_SW_OCP = 8'h00;
   localparam logic [7:0] WDO_RST_LIN_OCP = 8'h00;
   localparam int WDO_BIT_ENABLE = 0;
   localparam int WDO_BIT_RELOAD = 1;
   localparam logic [7:0] WDO_MASK_CTRL = 8'h03;
   localparam logic [7:0] WDO_MASK_SW_OCP = 8'h7F;
   localparam logic [7:0] WDO_MASK_LIN_OCP = 8'h3F;
   localparam int WDO_SW_SOURCES = 7;
   localparam int WDO_LIN_SOURCES = 6;
   localparam int WDO_CNT_W = 9;
   localparam logic [8:0] WDO_CNT_ZERO = 9'h000;
   localparam logic [8:0] WDO_CNT_ONE = 9'h001;
   typedef enum logic [1:0] {WDO_IDLE, WDO_RUN, WDO_EXPIRED} wdo_state_t;
endpackage : wdo_pkg

/* rtl/wdo_ocp_shutdown.sv */
/*
 Overcurrent shutdown decision: one registered pulse-free level that asks
 the power-state logic to turn the device off.
 Assumes overcurrent flags are synchronous to mclk.
*/
`timescale 1ns/1ps
module wdo_ocp_shutdown (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Policy and events
   input wire logic [6:0] switcherMask,
   input wire logic [5:0] linearMask,
   input wire logic [6:0] switcherOcp,
   input wire logic [5:0] linearOcp,
   // Result
   output logic turnOff
);
   logic turnOff_r;
   logic turnOff_nxt;

   always_comb begin
      turnOff_nxt = (|(switcherMask & switcherOcp))
                    | (|(linearMask & linearOcp));
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         turnOff_r <= 1'b0;
      end else begin
         turnOff_r <= turnOff_nxt;
      end
   end

   assign turnOff = turnOff_r;
endmodule : wdo_ocp_shutdown

/* rtl/wdo_downcounter.sv */
/*
 Watchdog seconds downcounter with reload and single expiry pulse.
 Assumes secTick is a one-cycle pulse per second on mclk.
*/
`timescale 1ns/1ps
module wdo_downcounter (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic enable,
   input wire logic reload,
   input wire logic [7:0] period,
   input wire logic secTick,
   // Status
   output logic expire,
   output logic [8:0] count
);
   wdo_pkg::wdo_state_t state_r;
   wdo_pkg::wdo_state_t state_nxt;
   logic [8:0] count_r;
   logic [8:0] count_nxt;
   logic expire_r;
   logic expire_nxt;
   logic [8:0] loadVal;

   // Field value plus one seconds
   assign loadVal = {1'b0, period} + wdo_pkg::WDO_CNT_ONE;

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      expire_nxt = 1'b0;
      case (state_r)
         wdo_pkg::WDO_IDLE: begin
            count_nxt = loadVal;
            if (enable) begin
               state_nxt = wdo_pkg::WDO_RUN;
            end
         end
         wdo_pkg::WDO_RUN: begin
            if (!enable) begin
               state_nxt = wdo_pkg::WDO_IDLE;
            end else if (reload) begin
               count_nxt = loadVal;
            end else if (secTick) begin
               count_nxt = count_r - wdo_pkg::WDO_CNT_ONE;
               if (count_r == wdo_pkg::WDO_CNT_ONE) begin
                  expire_nxt = 1'b1;
                  state_nxt = wdo_pkg::WDO_EXPIRED;
               end
            end
         end
         wdo_pkg::WDO_EXPIRED: begin
            // One event only; reload or disable rearms
            if (!enable) begin
               state_nxt = wdo_pkg::WDO_IDLE;
            end else if (reload) begin
               count_nxt = loadVal;
               state_nxt = wdo_pkg::WDO_RUN;
            end
         end
         default: begin
            state_nxt = wdo_pkg::WDO_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= wdo_pkg::WDO_IDLE;
         count_r <= wdo_pkg::WDO_CNT_ZERO;
         expire_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign expire = expire_r;
   assign count = count_r;
endmodule : wdo_downcounter

/* test/wdo_watchdog_ocp_ctrl_chk.sv */
/* Port assertions for the watchdog and overcurrent control block.
 Bound to the top module from the testbench; one clock domain. */
`timescale 1ns/1ps
module wdo_watchdog_ocp_ctrl_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   // Events and results
   input wire logic secTick,
   input wire logic loadState,
   input wire logic [6:0] switcherOcp,
   input wire logic [5:0] linearOcp,
   input wire logic watchdogExpire,
   input wire logic ocpTurnOff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   sequence s_wr(a); regWrite && regAddr == a && !loadState; endsequence
   sequence s_rd(a); regRead && !regWrite && regAddr == a; endsequence
   property p_rd_ctrl; s_wr(8'h1B) ##1 (!regWrite)[*2] ##1 s_rd(8'h1B) |=>
      regRdata == {7'h00, $past(regWdata[0], 4)}; endproperty
   property p_rd_period; s_wr(8'h1C) ##1 (!regWrite && !loadState)[*2] ##1 s_rd(8'h1C) |=>
      regRdata == $past(regWdata, 4); endproperty
   property p_ld_period; $rose(loadState) ##1 s_rd(8'h1C) |=> regRdata == 8'h00; endproperty
   property p_ld_lin; $rose(loadState) ##1 (!regWrite)[*3] ##0 s_rd(8'h1E) |=> regRdata == 8'h00; endproperty
   property p_ld_sw; loadState ##1 (loadState && regRead && !regWrite && regAddr == 8'h1D) |=> regRdata == 8'h00;
   endproperty
   property p_ocp_cause; ocpTurnOff |-> $past(|{switcherOcp, linearOcp}); endproperty
   property p_exp_pulse; watchdogExpire |=> !watchdogExpire; endproperty
   property p_exp_tick; watchdogExpire |-> $past(secTick) || $past(secTick, 2); endproperty
   ////////////////////////////////////////
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
   a_rd_period: assert property (p_rd_period) else $error("period readback wrong");
   a_ld_period: assert property (p_ld_period) else $error("period not defaulted");
   a_ld_lin: assert property (p_ld_lin) else $error("linear mask not defaulted");
   a_ld_sw: assert property (p_ld_sw) else $error("switcher mask not defaulted");
   a_ocp_cause: assert property (p_ocp_cause) else $error("turn-off without overcurrent");
   a_exp_pulse: assert property (p_exp_pulse) else $error("expiry longer than one cycle");
   a_exp_tick: assert property (p_exp_tick) else $error("expiry without tick");
endmodule : wdo_watchdog_ocp_ctrl_chk

/* test/wdo_watchdog_ocp_ctrl_tb_top.sv */
/* Testbench for the watchdog and overcurrent control block.
 Drives the register port directly; needs the checker compiled first. */
`timescale 1ns/1ps
module wdo_watchdog_ocp_ctrl_tb_top;
   logic mclk = 0, rst_n = 0, regWrite = 0, regRead = 0, secTick = 0, loadState = 0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
   logic [6:0] switcherOcp = 7'h00;
   logic [5:0] linearOcp = 6'h00;
   logic watchdogExpire, ocpTurnOff;
   int error_cnt = 0, n_tests = 0, cycles = 0;
   int per [3] = '{0, 2, 255};
   wdo_watchdog_ocp_ctrl i_wdo_watchdog_ocp_ctrl (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .secTick(secTick),
      .loadState(loadState), .switcherOcp(switcherOcp), .linearOcp(linearOcp),
      .watchdogExpire(watchdogExpire), .ocpTurnOff(ocpTurnOff));
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   ////////////////////////////////////////
   task conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task step;
      @(posedge mclk);
      #1;
   endtask : step
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      regWrite = 1;
      regAddr = a;
      regWdata = d;
      step;
      regWrite = 0;
      step;
      step;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      regRead = 1;
      regAddr = a;
      step;
      regRead = 0;
      step;
      chk(regRdata, e);
   endtask : rd
   // One second tick, expiry looked for over the next two cycles
   task tick(input logic e);
      logic seen;
      secTick = 1;
      step;
      seen = watchdogExpire;
      secTick = 0;
      step;
      seen = seen | watchdogExpire;
      step;
      chk({7'h00, seen}, {7'h00, e});
   endtask : tick
   ////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk);
      #1 rst_n = 1;
      rd(8'h1B, 8'h00);
      rd(8'h1C, 8'h00);
      rd(8'h1D, 8'h00);
      rd(8'h1E, 8'h00);
      rd(8'h1F, 8'h00);
      $display("reset values done");
      wr(8'h1B, 8'hFF);
      rd(8'h1B, 8'h01);
      wr(8'h1C, 8'hA5);
      rd(8'h1C, 8'hA5);
      wr(8'h1D, 8'hFF);
      rd(8'h1D, 8'h7F);
      wr(8'h1E, 8'hFF);
      rd(8'h1E, 8'h3F);
      $display("register access done");
      for (int i = 0; i < 13; i++) begin
         {linearOcp, switcherOcp} = 13'h0001 << i;
         step;
         step;
         chk({7'h00, ocpTurnOff}, 8'h01);
      end
      wr(8'h1D, 8'h7E);
      wr(8'h1E, 8'h3E);
      {linearOcp, switcherOcp} = 13'h0081;
      step;
      step;
      chk({7'h00, ocpTurnOff}, 8'h00);
      {linearOcp, switcherOcp} = 13'h0000;
      $display("overcurrent done");
      wr(8'h1B, 8'h00);
      wr(8'h1C, 8'h07);
      loadState = 1;
      step;
      rd(8'h1C, 8'h00);
      rd(8'h1E, 8'h00);
      rd(8'h1D, 8'h00);
      loadState = 0;
      rd(8'h1D, 8'h00);
      $display("load state done");
      for (int j = 0; j < 3; j++) begin
         wr(8'h1C, 8'(per[j]));
         wr(8'h1B, 8'h03);
         for (int t = 0; t <= per[j]; t++) begin
            if (t == 1) wr(8'h1B, 8'h01);
            tick(t == per[j]);
         end
         tick(1'b0);
         wr(8'h1B, 8'h03);
         for (int t = 0; t < per[j]; t++) tick(1'b0);
         wr(8'h1B, 8'h03);
         for (int t = 0; t < per[j]; t++) tick(1'b0);
         tick(1'b1);
         wr(8'h1B, 8'h00);
         tick(1'b0);
         tick(1'b0);
      end
      $display("watchdog done");
      wr(8'h1B, 8'h01);
      rst_n = 0;
      step;
      rst_n = 1;
      rd(8'h1B, 8'h00);
      $display("mid-run reset done");
      conclude();
   end
endmodule : wdo_watchdog_ocp_ctrl_tb_top
bind wdo_watchdog_ocp_ctrl wdo_watchdog_ocp_ctrl_chk i_wdo_watchdog_ocp_ctrl_chk (.mclk(mclk), .rst_n(rst_n),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .secTick(secTick), .loadState(loadState), .switcherOcp(switcherOcp), .linearOcp(linearOcp),
   .watchdogExpire(watchdogExpire), .ocpTurnOff(ocpTurnOff));
